/* File: rtl/periodic_tick_timer.sv */
// periodic tick timer with its status/control register on an AXI4-Lite slave
// Notes on behaviour
// - count clock is an internal 1 kHz reference or an external clock
// - one clock-select bit picks the count clock source
// - both sources keep counting in every power mode
// - with irq enable set, interrupts come at the selected period
// - at period end the flag sets and the next period starts at once
// - writing one to acknowledge clears the flag and drops the request
// - period select offers exactly seven periods from the chosen clock
// - writing 0x57 gives internal clock, irq on, ack, longest period
//
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module periodic_tick_timer (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic ext_tick_clock,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic tick_irq
);
  logic ref_pulse;
  logic ext_prev;
  logic ext_rise;
  logic tick_en;
  logic [tick_pkg::TICK_W-1:0] tick_count;
  logic [tick_pkg::TICK_W-1:0] next_tick_count;
  logic tick_timeout_flag;
  logic next_tick_timeout_flag;
  logic tick_clock_select;
  logic next_tick_clock_select;
  logic tick_irq_enable;
  logic next_tick_irq_enable;
  logic [2:0] tick_period_select;
  logic [2:0] next_tick_period_select;
  logic next_tick_irq;
  logic period_end;
  // bus state
  logic aw_held;
  logic next_aw_held;
  logic [31:0] aw_addr;
  logic [31:0] next_aw_addr;
  logic w_held;
  logic next_w_held;
  logic [7:0] w_data;
  logic [7:0] next_w_data;
  logic w_lane0;
  logic next_w_lane0;
  logic next_awready;
  logic next_wready;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_arready;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic do_write;
  logic write_hit;
  logic [7:0] tick_status_control;

  function automatic logic addr_hit(input logic [31:0] a);
    return a[31:2] == 30'(tick_pkg::STATUS_CONTROL_ADDR >> 2);
  endfunction : addr_hit

  tick_ref_divider tick_ref_divider_i (
    .clock(clock),
    .sys_rst(sys_rst),
    .ref_pulse(ref_pulse)
  );

  assign ext_rise = ext_tick_clock & ~ext_prev;
  // no power-mode input gates either source
  assign tick_en = tick_clock_select ? ext_rise : ref_pulse;
  assign period_end = tick_en && (tick_period_select != 3'h0) &&
    (tick_count >= tick_pkg::period_limit(tick_period_select));

  assign tick_status_control = {tick_timeout_flag, 1'b0, tick_clock_select,
    tick_irq_enable, 1'b0, tick_period_select};

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign write_hit = do_write && addr_hit(aw_addr) && w_lane0;

  // timer and register state
  always_comb begin
    next_tick_count = tick_count;
    next_tick_timeout_flag = tick_timeout_flag;
    next_tick_clock_select = tick_clock_select;
    next_tick_irq_enable = tick_irq_enable;
    next_tick_period_select = tick_period_select;
    if (write_hit) begin
      next_tick_clock_select = w_data[tick_pkg::CLKSEL_BIT];
      next_tick_irq_enable = w_data[tick_pkg::IRQEN_BIT];
      next_tick_period_select = w_data[tick_pkg::PSEL_LSB +: 3];
      if (w_data[tick_pkg::ACK_BIT]) begin
        next_tick_timeout_flag = 1'b0;
      end
    end
    if (tick_period_select == 3'h0) begin
      next_tick_count = '0;
    end else if (period_end) begin
      next_tick_count = '0;
      next_tick_timeout_flag = 1'b1; // set beats a same-cycle ack
    end else if (tick_en) begin
      next_tick_count = tick_count + 1'b1;
    end
    if (next_tick_period_select == 3'h0) begin
      next_tick_timeout_flag = 1'b0;
    end
    next_tick_irq = next_tick_timeout_flag & next_tick_irq_enable;
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ext_prev <= 1'b0;
      tick_count <= '0;
      tick_timeout_flag <= tick_pkg::CTRL_RESET[tick_pkg::FLAG_BIT];
      tick_clock_select <= tick_pkg::CTRL_RESET[tick_pkg::CLKSEL_BIT];
      tick_irq_enable <= tick_pkg::CTRL_RESET[tick_pkg::IRQEN_BIT];
      tick_period_select <= tick_pkg::CTRL_RESET[tick_pkg::PSEL_LSB +: 3];
      tick_irq <= 1'b0;
    end else begin
      ext_prev <= ext_tick_clock;
      tick_count <= next_tick_count;
      tick_timeout_flag <= next_tick_timeout_flag;
      tick_clock_select <= next_tick_clock_select;
      tick_irq_enable <= next_tick_irq_enable;
      tick_period_select <= next_tick_period_select;
      tick_irq <= next_tick_irq;
    end
  end

  // axi4-lite slave: address and data latched independently, then one response
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_arready = 1'b0;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata[7:0];
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = addr_hit(aw_addr) ? tick_pkg::RESP_OKAY : tick_pkg::RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    // each ready only while its own channel holds nothing and no response waits; keeps one write in flight
    next_awready = !next_aw_held && !next_bvalid && !(s_axi_awvalid && s_axi_awready);
    next_wready = !next_w_held && !next_bvalid && !(s_axi_wvalid && s_axi_wready);
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata = addr_hit(s_axi_araddr) ? {24'h000000, tick_status_control} : 32'h00000000;
      next_rresp = addr_hit(s_axi_araddr) ? tick_pkg::RESP_OKAY : tick_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end else if (!s_axi_rvalid && !s_axi_arready) begin
      next_arready = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      aw_held <= 1'b0;
      aw_addr <= 32'h00000000;
      w_held <= 1'b0;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tick_pkg::RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= tick_pkg::RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_lane0 <= next_w_lane0;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // checks
  property p_irq_follows;
    @(posedge clock) disable iff (sys_rst)
      1'b1 |-> tick_irq == (tick_timeout_flag && tick_irq_enable);
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("irq mismatch");

  property p_period_sets_flag;
    @(posedge clock) disable iff (sys_rst)
      // a same-cycle write of select zero legally keeps the flag clear
      period_end && next_tick_period_select != 3'h0 |=>
        tick_timeout_flag && tick_count == '0;
  endproperty
  a_period_sets_flag: assert property (p_period_sets_flag) else $error("no flag at end");

  property p_ack_clears;
    @(posedge clock) disable iff (sys_rst)
      write_hit && w_data[tick_pkg::ACK_BIT] && !period_end |=> !tick_timeout_flag;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("ack did not clear");

  property p_zero_stops;
    @(posedge clock) disable iff (sys_rst)
      tick_period_select == 3'h0 |=> tick_count == '0 && !tick_timeout_flag;
  endproperty
  a_zero_stops: assert property (p_zero_stops) else $error("select zero runs");

  property p_write_57;
    @(posedge clock) disable iff (sys_rst)
      write_hit && w_data == 8'h57 && !period_end |=> tick_status_control == 8'h17;
  endproperty
  a_write_57: assert property (p_write_57) else $error("0x57 setup wrong");

  property p_ack_reads_zero;
    @(posedge clock) disable iff (sys_rst)
      s_axi_rvalid |-> s_axi_rdata[tick_pkg::ACK_BIT] == 1'b0;
  endproperty
  a_ack_reads_zero: assert property (p_ack_reads_zero) else $error("ack reads one");

  property p_count_source;
    @(posedge clock) disable iff (sys_rst)
      tick_period_select != 3'h0 && !tick_en && !write_hit |=> $stable(tick_count);
  endproperty
  a_count_source: assert property (p_count_source) else $error("count moved");

  property p_ref_rate;
    @(posedge clock) disable iff (sys_rst)
      ref_pulse |=> !ref_pulse [*8];
  endproperty
  a_ref_rate: assert property (p_ref_rate) else $error("ref pulse too fast");

  c_irq: cover property (@(posedge clock) disable iff (sys_rst) $rose(tick_irq));
  c_ack: cover property (@(posedge clock) disable iff (sys_rst) $fell(tick_irq));
  c_ext: cover property (@(posedge clock) disable iff (sys_rst) period_end && tick_clock_select);
endmodule : periodic_tick_timer

/* File: rtl/tick_pkg.sv */
// constants for the periodic tick timer and its bus slave
package tick_pkg;
  localparam logic [3:0] STATUS_CONTROL_ADDR = 4'h0;
  localparam int FLAG_BIT = 7;
  localparam int ACK_BIT = 6;
  localparam int CLKSEL_BIT = 5;
  localparam int IRQEN_BIT = 4;
  localparam int PSEL_LSB = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h37;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // internal reference rate and system clock rate, in Hz
  localparam int REF_HZ = 1000;
  localparam int CLOCK_HZ = 10000000;
  localparam int REF_DIV = CLOCK_HZ / REF_HZ;
  localparam int DIV_W = 14;
  localparam int TICK_W = 10;
  localparam int PERIOD_COUNT = 7;
  // periods in reference ticks, index 1..7: 8,32,64,128,256,512,1024 ms
  function automatic logic [TICK_W-1:0] period_limit(input logic [2:0] sel);
    logic [TICK_W-1:0] lim;
    lim = 10'h000;
    unique case (sel)
      3'h1: lim = 10'h007;
      3'h2: lim = 10'h01f;
      3'h3: lim = 10'h03f;
      3'h4: lim = 10'h07f;
      3'h5: lim = 10'h0ff;
      3'h6: lim = 10'h1ff;
      3'h7: lim = 10'h3ff;
      default: lim = 10'h000;
    endcase
    return lim;
  endfunction : period_limit
endpackage : tick_pkg

/* File: rtl/tick_ref_divider.sv */
// divides the system clock down to a one-cycle 1 kHz reference pulse
`timescale 1ns/1ps
module tick_ref_divider (
  input wire logic clock,
  input wire logic sys_rst,
  output logic ref_pulse
);
  logic [tick_pkg::DIV_W-1:0] count;
  logic [tick_pkg::DIV_W-1:0] next_count;
  logic next_ref_pulse;

  // runs in every power mode; nothing here gates it
  always_comb begin
    next_ref_pulse = 1'b0;
    next_count = count + 1'b1;
    if (count == tick_pkg::DIV_W'(tick_pkg::REF_DIV - 1)) begin
      next_count = '0;
      next_ref_pulse = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count <= '0;
      ref_pulse <= 1'b0;
    end else begin
      count <= next_count;
      ref_pulse <= next_ref_pulse;
    end
  end
endmodule : tick_ref_divider

/* File: dv/test_periodic_tick_timer.sv */
// register-level bench for the periodic tick timer
`timescale 1ns/1ps
module test_periodic_tick_timer;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic ext_tick_clock = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, tick_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [1:0] ext_div = 2'h0;
  logic [31:0] ext_edges = 32'h0;
  logic [31:0] e0, rd;
  logic [1:0] rs;
  logic [31:0] per_ticks [1:7] = '{32'h8, 32'h20, 32'h40, 32'h80, 32'h100, 32'h200, 32'h400};
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;
  localparam logic [31:0] CTRL = {28'h0, tick_pkg::STATUS_CONTROL_ADDR};

  periodic_tick_timer periodic_tick_timer_i (.clock(clock), .sys_rst(sys_rst),
    .ext_tick_clock(ext_tick_clock), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .tick_irq(tick_irq));

  initial begin
    forever #50 clock = ~clock;
  end

  // external count clock, one rising edge every four system clocks
  always @(posedge clock) begin
    ext_div <= ext_div + 2'h1;
    ext_tick_clock <= ext_div[1];
    if (ext_div == 2'h2) ext_edges <= ext_edges + 32'h1;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: watchdog expired", $time);
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus_write(input logic [31:0] a, input logic [7:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        done = 1'b1;
      end
    end
    s_axi_bready <= 1'b0;
  endtask : bus_write

  task automatic bus_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        done = 1'b1;
      end
    end
    s_axi_rready <= 1'b0;
  endtask : bus_read

  task automatic wr_ctrl(input logic [7:0] d);
    logic [1:0] r;
    bus_write(CTRL, d, 4'h1, r);
    check({30'h0, r}, {30'h0, tick_pkg::RESP_OKAY});
  endtask : wr_ctrl

  // register value and irq level together
  task automatic expect_ctrl(input logic [7:0] v, input logic irq);
    bus_read(CTRL, rd, rs);
    check(rd, {24'h0, v});
    check({31'h0, tick_irq}, {31'h0, irq});
  endtask : expect_ctrl

  task automatic wait_irq;
    do @(posedge clock); while (tick_irq !== 1'b1);
  endtask : wait_irq

  initial begin
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    expect_ctrl(8'h00, 1'b0);
    $display("test reset values done");
    bus_write(32'h4, 8'h37, 4'h1, rs);
    check({30'h0, rs}, {30'h0, tick_pkg::RESP_SLVERR});
    bus_read(32'h4, rd, rs);
    check(rd, 32'h0);
    check({30'h0, rs}, {30'h0, tick_pkg::RESP_SLVERR});
    bus_write(CTRL, 8'h37, 4'h0, rs);
    check({30'h0, rs}, {30'h0, tick_pkg::RESP_OKAY});
    expect_ctrl(8'h00, 1'b0);
    $display("test unmapped and masked writes done");
    // the first period after a change may be partial, so measure the second
    for (int s = 1; s <= 7; s++) begin
      wr_ctrl(8'h70 | 8'(s));
      wait_irq();
      e0 = ext_edges;
      expect_ctrl(8'hb0 | 8'(s), 1'b1);
      wr_ctrl(8'h70 | 8'(s));
      wait_irq();
      check(ext_edges - e0, per_ticks[s]);
    end
    $display("test period table done");
    wr_ctrl(8'h77);
    expect_ctrl(8'h37, 1'b0);
    wr_ctrl(8'h61);
    repeat (80) @(posedge clock);
    expect_ctrl(8'ha1, 1'b0);
    $display("test acknowledge and enable done");
    wr_ctrl(8'h70);
    repeat (200) @(posedge clock);
    expect_ctrl(8'h30, 1'b0);
    wr_ctrl(8'h51);
    repeat (400) @(posedge clock);
    expect_ctrl(8'h11, 1'b0);
    wr_ctrl(8'h57);
    expect_ctrl(8'h17, 1'b0);
    $display("test stop, source and setup word done");
    tally_and_finish();
  end
endmodule : test_periodic_tick_timer
